// ### common/fsc_pkg.sv
// package of register map, field layout and constants for the frame-sync config slice
package fsc_pkg;
   localparam int FSC_AW = 8;
   localparam int FSC_DW = 8;
   localparam int FSC_DIV_W = 13;
   localparam int FSC_DUTY_W = 11;
   localparam logic [7:0] FSC_ADDR_DIV_HI = 8'hA6;
   localparam logic [7:0] FSC_ADDR_DIV_LO = 8'hA7;
   localparam logic [7:0] FSC_ADDR_STATUS = 8'hA8;
   localparam logic [7:0] FSC_RESET_DIV_HI = 8'h00;
   localparam logic [7:0] FSC_RESET_DIV_LO = 8'h00;
   localparam int FSC_LO_DIV_MSB = 7;
   localparam int FSC_LO_DIV_LSB = 3;
   localparam int FSC_LO_SEL_BIT = 2;
   localparam int FSC_LO_HYS_MSB = 1;
   localparam int FSC_HYS_STEP_BITS = 1;
   localparam logic [1:0] FSC_HYS_OFF = 2'h0;
   localparam logic [1:0] FSC_HYS_11B = 2'h1;
   localparam logic [1:0] FSC_HYS_10B = 2'h2;
   localparam logic [1:0] FSC_HYS_8B = 2'h3;
   // divider constants per loop rate code 5/10/20/40 MHz
   localparam logic [7:0] FSC_K_5M = 8'h1A;
   localparam logic [7:0] FSC_K_10M = 8'h32;
   localparam logic [7:0] FSC_K_20M = 8'h62;
   localparam logic [7:0] FSC_K_40M = 8'hC4;
endpackage

// ### common/fsc_cfg_if.sv
// interface carrying decoded configuration between the slice modules
`timescale 1ns/1ps
`default_nettype none
interface fsc_cfg_if;
   logic [1:0] hys_mode;
   logic sync_enable;
   logic [12:0] lock_div;
   modport src (output hys_mode, output sync_enable, output lock_div);
   modport dst (input hys_mode, input sync_enable, input lock_div);
endinterface
`default_nettype wire

// ### src/fsc_sync2.sv
// two-flop synchroniser for one pin input
`timescale 1ns/1ps
`default_nettype none
module fsc_sync2 (
   input wire logic clk_in, // system clock
   input wire logic rst_n_in, // async reset, active low
   input wire logic d_in, // asynchronous level
   output logic q_out // synchronised level
);
   logic meta_q, meta_d, sync_q, sync_d;
   // next values: first stage feeds only the second
   always_comb begin
      meta_d = d_in;
      sync_d = meta_q;
   end
   // registers
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end
   assign q_out = sync_q;
endmodule
`default_nettype wire

// ### src/fsc_hyst.sv
// pwm input duty filter with one-lsb hysteresis at a selectable resolution
`timescale 1ns/1ps
`default_nettype none
module fsc_hyst
   import fsc_pkg::*;
(
   input wire logic clk_in, // system clock
   input wire logic rst_n_in, // async reset, active low
   fsc_cfg_if.dst cfg, // decoded configuration
   input wire logic sample_in, // new measurement valid, one cycle
   input wire logic [10:0] duty_in, // measured duty, 11 bits
   output logic [10:0] duty_out // held duty
);
   logic [10:0] held_q, held_d;
   logic [10:0] diff;
   logic [10:0] step;
   // one lsb at the chosen resolution, in 11-bit units
   always_comb begin
      case (cfg.hys_mode)
         FSC_HYS_11B: step = 11'h001;
         FSC_HYS_10B: step = 11'h002;
         FSC_HYS_8B: step = 11'h008;
         default: step = 11'h000;
      endcase
   end
   // update only on a move larger than one lsb; off passes every sample
   always_comb begin
      diff = (duty_in > held_q) ? duty_in - held_q : held_q - duty_in;
      held_d = held_q;
      if (sample_in) begin
         if (cfg.hys_mode == FSC_HYS_OFF) begin
            held_d = duty_in;
         end else if (diff > step) begin
            held_d = duty_in;
         end
      end
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         held_q <= 11'h000;
      end else begin
         held_q <= held_d;
      end
   end
   assign duty_out = held_q;
endmodule
`default_nettype wire

// ### src/fsc_top.sv
// frame-sync lock divider and pwm input configuration slice
`timescale 1ns/1ps
`default_nettype none
module fsc_top
   import fsc_pkg::*;
(
   input wire logic sys_clk_in, // 10 MHz system clock
   input wire logic reset_n_in, // async reset, active low
   input wire logic [fsc_pkg::FSC_AW-1:0] addr_in, // register address
   input wire logic [fsc_pkg::FSC_DW-1:0] wdata_in, // write data
   input wire logic wr_in, // write strobe
   input wire logic rd_in, // read strobe
   output logic [fsc_pkg::FSC_DW-1:0] rdata_out, // read data, cycle after strobe
   input wire logic sync_enable_in, // frame-sync enable bit from neighbour register
   input wire logic [1:0] loop_rate_in, // pwm depth bits choosing loop rate
   input wire logic frame_sync_in, // frame-sync pin, asynchronous
   input wire logic duty_valid_in, // pwm input measurement valid
   input wire logic [10:0] duty_meas_in, // pwm input measurement
   output logic [12:0] lock_div_out, // divider to the loop, zero when free running
   output logic loop_locked_mode_out, // loop follows frame sync
   output logic loop_sync_out, // synchronised frame-sync to loop, gated
   output logic use_rate_field_out, // pwm rate field sets frequency
   output logic freq_set_resistor_en_out, // external set resistor enabled
   output logic [7:0] div_const_out, // divider constant for current loop rate
   output logic [10:0] duty_out // filtered pwm input duty
);
   logic [7:0] div_hi_q, div_hi_d;
   logic [7:0] div_lo_q, div_lo_d;
   logic [7:0] rdata_q, rdata_d;
   logic [12:0] lock_div_q, lock_div_d;
   logic locked_q, locked_d;
   logic sel_q, sel_d;
   logic gsync_q, gsync_d;
   logic fs_sync;
   fsc_cfg_if cfg_bus ();

   // loop-rate code to divider constant, used only for div_const_out; status read does not carry it
   function automatic logic [7:0] fsc_k(input logic [1:0] code);
      case (code)
         2'h0: fsc_k = FSC_K_5M;
         2'h1: fsc_k = FSC_K_10M;
         2'h2: fsc_k = FSC_K_20M;
         default: fsc_k = FSC_K_40M;
      endcase
   endfunction

   // the pin crosses into sys_clk before anything looks at it
   fsc_sync2 u_sync (
      .clk_in(sys_clk_in),
      .rst_n_in(reset_n_in),
      .d_in(frame_sync_in),
      .q_out(fs_sync)
   );

   // register writes; a write to an unmapped address is dropped
   always_comb begin
      div_hi_d = div_hi_q;
      div_lo_d = div_lo_q;
      if (wr_in) begin
         if (addr_in == FSC_ADDR_DIV_HI) begin
            div_hi_d = wdata_in;
         end
         if (addr_in == FSC_ADDR_DIV_LO) begin
            div_lo_d = wdata_in;
         end
      end
   end

   // read mux; unmapped reads answer zero, data held only one cycle
   always_comb begin
      rdata_d = 8'h00;
      if (rd_in) begin
         case (addr_in)
            FSC_ADDR_DIV_HI: rdata_d = div_hi_q;
            FSC_ADDR_DIV_LO: rdata_d = div_lo_q;
            FSC_ADDR_STATUS: rdata_d = {6'h00, gsync_q, locked_q};
            default: rdata_d = 8'h00;
         endcase
      end
   end

   // divider assembly and loop steering, registered so outputs come from flops
   always_comb begin
      locked_d = sync_enable_in;
      lock_div_d = 13'h0000;
      if (sync_enable_in) begin
         lock_div_d = {div_hi_q, div_lo_q[FSC_LO_DIV_MSB:FSC_LO_DIV_LSB]};
      end
      sel_d = div_lo_q[FSC_LO_SEL_BIT];
      gsync_d = sync_enable_in & fs_sync;
   end

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         div_hi_q <= FSC_RESET_DIV_HI;
         div_lo_q <= FSC_RESET_DIV_LO;
         rdata_q <= 8'h00;
         lock_div_q <= 13'h0000;
         locked_q <= 1'b0;
         sel_q <= 1'b0;
         gsync_q <= 1'b0;
      end else begin
         div_hi_q <= div_hi_d;
         div_lo_q <= div_lo_d;
         rdata_q <= rdata_d;
         lock_div_q <= lock_div_d;
         locked_q <= locked_d;
         sel_q <= sel_d;
         gsync_q <= gsync_d;
      end
   end

   // configuration to the input filter
   assign cfg_bus.hys_mode = div_lo_q[FSC_LO_HYS_MSB:0];
   assign cfg_bus.sync_enable = locked_q;
   assign cfg_bus.lock_div = lock_div_q;

   fsc_hyst u_hyst (
      .clk_in(sys_clk_in),
      .rst_n_in(reset_n_in),
      .cfg(cfg_bus),
      .sample_in(duty_valid_in),
      .duty_in(duty_meas_in),
      .duty_out(duty_out)
   );

   // software computes the divider from this constant; exposed as a hint only
   assign div_const_out = fsc_k(loop_rate_in);
   assign rdata_out = rdata_q;
   assign lock_div_out = lock_div_q;
   assign loop_locked_mode_out = locked_q;
   assign loop_sync_out = gsync_q;
   assign use_rate_field_out = ~sel_q;
   assign freq_set_resistor_en_out = sel_q;
endmodule
`default_nettype wire

// ### verification/fsc_top_properties.sv
// port assertions of the frame-sync config slice
`timescale 1ns/1ps
`default_nettype none
module fsc_chk (
   input wire logic sys_clk_in, // clock
   input wire logic reset_n_in, // reset
   input wire logic [7:0] addr_in, // address
   input wire logic [7:0] wdata_in, // data
   input wire logic wr_in, // write
   input wire logic sync_enable_in, // sync on
   input wire logic duty_valid_in, // sample
   input wire logic [10:0] duty_meas_in, // measure
   input wire logic [12:0] lock_div_out, // divider
   input wire logic loop_locked_mode_out, // locked
   input wire logic loop_sync_out, // sync out
   input wire logic use_rate_field_out, // rate
   input wire logic freq_set_resistor_en_out, // resistor
   input wire logic [10:0] duty_out // duty
);
   logic [1:0] hys_q; // mode is not at the ports, so it is shadowed
   logic [10:0] dd, st;
   always_ff @(posedge sys_clk_in or negedge reset_n_in)
      if (!reset_n_in) hys_q <= 2'h0;
      else if (wr_in && addr_in == 8'hA7) hys_q <= wdata_in[1:0];
   assign dd = duty_meas_in > duty_out ? duty_meas_in - duty_out : duty_out - duty_meas_in;
   assign st = hys_q == 2'h3 ? 11'h008 : hys_q == 2'h2 ? 11'h002 : 11'h001;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!reset_n_in);
   chk_div_high: assert property (wr_in && addr_in == 8'hA6 ##1 sync_enable_in
      |=> lock_div_out[12:5] == $past(wdata_in, 2)) else $error("bad divider");
   chk_div_free: assert property (!sync_enable_in |=> lock_div_out == 13'h0000)
      else $error("divider not gated");
   chk_sync_off: assert property (!sync_enable_in |=> !loop_sync_out)
      else $error("sync not gated");
   chk_lock_mode: assert property (loop_locked_mode_out == $past(sync_enable_in))
      else $error("locked mode does not follow enable");
   chk_sel_res: assert property (wr_in && addr_in == 8'hA7 |-> ##2
      freq_set_resistor_en_out == $past(wdata_in[2], 2) && use_rate_field_out
      != freq_set_resistor_en_out) else $error("bad source select");
   // the write guard covers one possible decode stage of the mode
   chk_hys_move: assert property (duty_valid_in && !$past(wr_in) && (hys_q == 2'h0 || dd > st)
      |=> duty_out == $past(duty_meas_in)) else $error("duty not taken");
   chk_hys_hold: assert property (duty_valid_in && !$past(wr_in) && hys_q != 2'h0 && dd <= st
      |=> $stable(duty_out)) else $error("duty moved");
   cover property (wr_in && addr_in == 8'hA6 ##1 sync_enable_in);
   cover property (duty_valid_in && hys_q == 2'h3 && dd <= st);
   cover property (wr_in && addr_in == 8'hA7 && wdata_in[2]);
endmodule
`default_nettype wire

// ### verification/tb.sv
// self-checking bench of the frame-sync config slice
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, sen = 1'b0, fs = 1'b0, dv = 1'b0, ls;
   logic lm, urf, fsr;
   logic [7:0] addr = 8'h00, wd = 8'h00, rdata, kc, hi, lo;
   logic [1:0] lr = 2'h0;
   logic [10:0] dm = 11'h000, duty, v, s;
   logic [12:0] div;
   int err_count = 0, check_count = 0;
   fsc_top i_dut (.sys_clk_in(clk), .reset_n_in(rst_n), .addr_in(addr), .wdata_in(wd),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .sync_enable_in(sen), .loop_rate_in(lr),
      .frame_sync_in(fs), .duty_valid_in(dv), .duty_meas_in(dm), .lock_div_out(div),
      .loop_locked_mode_out(lm), .loop_sync_out(ls), .use_rate_field_out(urf),
      .freq_set_resistor_en_out(fsr), .div_const_out(kc), .duty_out(duty));
   // 10 MHz clock
   initial forever #50 clk = ~clk;
   // loop-rate code to divider constant for 5/10/20/40 MHz
   function automatic logic [7:0] exp_k(input int c);
      return c == 0 ? 8'h1A : c == 1 ? 8'h32 : c == 2 ? 8'h62 : 8'hC4;
   endfunction
   // one lsb of the chosen input resolution, in 11-bit units
   function automatic logic [10:0] exp_step(input int m);
      return m == 3 ? 11'h008 : m == 2 ? 11'h002 : 11'h001;
   endfunction
   task automatic end_sim;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input logic [12:0] seen, input logic [12:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // a write leaves its strobe up so that the next access follows with no gap
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      if (!w) begin
         @(posedge clk);
         rd <= 1'b0;
         #1 check(rdata, d);
      end
   endtask
   task automatic samp(input logic [10:0] d, input logic [10:0] e);
      @(posedge clk);
      dm <= d;
      dv <= 1'b1;
      @(posedge clk);
      dv <= 1'b0;
      #1 check(duty, e);
   endtask
   // cycle ceiling against a hang
   initial begin
      repeat (5000) @(posedge clk);
      err_count++;
      end_sim;
   end
   initial begin
      void'($urandom(15));
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         hi = i == 0 ? 8'hFF : 8'($urandom);
         lo = i == 0 ? 8'hFF : 8'($urandom);
         acc(1'b1, 8'hA7, lo);
         sen <= !i[0];
         acc(1'b1, 8'hA6, hi);
         acc(1'b0, 8'hA6, hi);
         acc(1'b0, 8'hA7, lo);
         @(posedge clk);
         #1 check(div, !i[0] ? {hi, lo[7:3]} : 13'h0000);
         check({urf, fsr}, {!lo[2], lo[2]});
         check(lm, !i[0]);
      end
      for (int c = 0; c < 4; c++) begin
         @(posedge clk);
         lr <= 2'(c);
         #1 check(kc, exp_k(c));
      end
      $display("register test done");
      @(posedge clk);
      sen <= 1'b1;
      fs <= 1'b1;
      acc(1'b0, 8'h55, 8'h00);
      acc(1'b0, 8'hA8, 8'h03);
      @(posedge clk);
      sen <= 1'b0;
      @(posedge clk);
      #1 check(ls, 1'b0);
      $display("sync test done");
      // a step at the limit is held (taken with the filter off), one more is taken
      for (int m = 0; m < 4; m++) begin
         v = 11'($urandom_range(1900, 100));
         s = exp_step(m);
         acc(1'b1, 8'hA7, 8'h00);
         acc(1'b0, 8'hA7, 8'h00);
         samp(v, v);
         acc(1'b1, 8'hA7, 8'(m));
         acc(1'b0, 8'hA7, 8'(m));
         samp(v + s, m == 0 ? v + s : v);
         samp(v - s - 11'h001, v - s - 11'h001);
      end
      $display("hysteresis test done");
      end_sim;
   end
endmodule
bind fsc_top fsc_chk i_chk (.sys_clk_in, .reset_n_in, .addr_in, .wdata_in, .wr_in,
   .sync_enable_in, .duty_valid_in, .duty_meas_in, .lock_div_out, .loop_locked_mode_out,
   .loop_sync_out,
   .use_rate_field_out, .freq_set_resistor_en_out, .duty_out);
`default_nettype wire
